// *** verilog/wdw_pkg.sv ***
// wdw_pkg: constants shared by the watchdog and wake-up control block.
// assumes a 20 MHz system clock and a 32-bit avalon-mm register bus.
package wdw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_WDT_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RST_CAUSE  = 8'h04;
  localparam logic [7:0] OFS_WAKE_EN    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;

  // watchdog_control layout: key in [7:3], period select in [2:0]
  localparam int KEY_LSB = 3;
  localparam int SEL_LSB = 0;
  localparam logic [4:0] KEY_ENABLE  = 5'h0a;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [7:0] WDT_CTRL_POR = 8'h53;
  localparam logic [2:0] SEL_POR      = 3'h3;
  localparam int PERIOD_BASE = 8;

  // reset_cause_flags bit positions
  localparam int RC_WDT_KEY   = 0;
  localparam int RC_LV_KEY    = 1;
  localparam int RC_LV_RESET  = 2;

  // status register bit positions
  localparam int ST_PDF  = 0;
  localparam int ST_TO   = 1;
  localparam int ST_DOWN = 2;

  // irq status / mask bit positions
  localparam int EV_OVF  = 0;
  localparam int EV_KEY  = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_W    = 3;

  // timing
  localparam int CLK_PERIOD_NS        = 50;
  localparam int KEY_RESET_DELAY_NS   = 1000;
  localparam int KEY_RESET_DELAY_CYC  =
    (KEY_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 16;

  typedef enum logic [0:0] {
    WDW_RUN  = 1'b0,
    WDW_DOWN = 1'b1
  } wdw_mode_t;
endpackage

// *** verilog/wdw_top.sv ***
// wdw_top: watchdog timer with keyed enable plus power-down wake-up logic.
// assumes cpu strobes are one-cycle pulses synchronous to clk_sys and that
// slow_internal_osc is a synchronous level sampled here for its rising edge.
//
// How it works
// - asleep or idle, wake on enabled pin fall, interrupt, or watchdog overflow
// - power-down instruction enters low power and sets power_down_flag
// - power_down_flag clears on power-up and on clear-watchdog instruction
// - overflow while down wakes, sets timeout_flag, resets only pc and sp
// - per-pin wake enable; pin wake resumes after the power-down instruction
// - disabled or stack-full interrupt wake resumes after power-down, stays pending
// - enabled interrupt with stack room wakes into normal interrupt response
// - request flag already set at entry cannot wake the device
// - watchdog counts slow oscillator cycles, period two to (8 + select)
// - key 01010 enables, 10101 disables, other values reset after a delay
// - illegal key reset sets key reset flag; only software or rst_b clears it
// - at power-on the key reads 01010 and period select 011
// - overflow in normal operation gives full device reset and sets timeout_flag
// - count cleared by key reset, clear-watchdog, or power-down instruction
// - on entry count cleared, timeout_flag cleared, power_down_flag set
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module wdw_top #(
  parameter int PINS = 8,
  parameter int IRQS = 8,
  parameter int KEY_DELAY_CYC = wdw_pkg::KEY_RESET_DELAY_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              pdown_instr,
  input  wire logic              clrwdt_instr,
  input  wire logic              slow_internal_osc,
  input  wire logic [PINS-1:0]   wake_pins,
  input  wire logic [IRQS-1:0]   irq_req,
  input  wire logic [IRQS-1:0]   irq_enabled,
  input  wire logic              stack_full,
  output logic                   low_power,
  output logic                   wake_resume,
  output logic                   wake_service,
  output logic                   pc_sp_reset,
  output logic                   device_reset,
  output logic                   power_down_flag,
  output logic                   timeout_flag,
  output logic                   irq
);
  localparam int DLY_W = $clog2(KEY_DELAY_CYC + 1);
  localparam int EV_W_C = wdw_pkg::EV_W;

  function automatic logic is_down(input wdw_pkg::wdw_mode_t m);
    is_down = (m == wdw_pkg::WDW_DOWN);
  endfunction

  function automatic logic sel_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    sel_hit = (addr == ofs);
  endfunction

  logic                       waitrequest_r;
  logic                       waitrequest_nxt;
  logic [31:0]                readdata_r;
  logic [7:0]                 wdt_ctrl_r;
  logic                       wdt_key_flag_r;
  logic [PINS-1:0]            wake_en_r;
  logic [EV_W_C-1:0]          irq_status_r;
  logic [EV_W_C-1:0]          irq_mask_r;
  logic                       irq_r;
  logic                       pdf_r;
  logic                       to_r;
  wdw_pkg::wdw_mode_t         mode_r;
  logic [wdw_pkg::CNT_W-1:0]  cnt_r;
  logic [wdw_pkg::CNT_W-1:0]  cnt_inc;
  logic                       osc_prev_r;
  logic [PINS-1:0]            pins_prev_r;
  logic [IRQS-1:0]            blocked_r;
  logic                       key_pend_r;
  logic [DLY_W-1:0]           key_dly_r;
  logic                       key_reset;
  logic                       wr_take;
  logic                       rd_take;
  logic                       osc_tick;
  logic                       wdt_en;
  logic                       ovf;
  logic [PINS-1:0]            pin_fall;
  logic [IRQS-1:0]            irq_wake;
  logic                       any_wake;
  logic                       wake_resume_r;
  logic                       wake_service_r;
  logic                       pc_sp_reset_r;
  logic                       device_reset_r;
  logic [4:0]                 key_wr;
  logic [EV_W_C-1:0]          ev_set;
  logic [EV_W_C-1:0]          ev_clr;
  logic [31:0]                rd_mux;
  logic [2:0]                 period_sel;
  logic                       pd_enter;

  // bus: one wait cycle, a write taken at the edge where waitrequest is low
  assign waitrequest_nxt = ~((avs_read | avs_write) & waitrequest_r);
  assign wr_take = avs_write & ~waitrequest_r;
  assign rd_take = avs_read & waitrequest_r;
  assign key_wr  = avs_writedata[wdw_pkg::KEY_LSB +: 5];

  assign osc_tick = slow_internal_osc & ~osc_prev_r;
  assign wdt_en   = wdt_ctrl_r[wdw_pkg::KEY_LSB +: 5] == wdw_pkg::KEY_ENABLE;
  assign cnt_inc  = cnt_r + 16'h0001;
  assign period_sel = wdt_ctrl_r[wdw_pkg::SEL_LSB +: 3];
  // overflow when the selected bit flips to one
  // limitation: lowering the select under a high count overflows at once
  assign ovf = wdt_en & osc_tick &
    cnt_inc[wdw_pkg::PERIOD_BASE + period_sel];

  // pin history resets low, so a pin idling low shows no false fall
  assign pin_fall = pins_prev_r & ~wake_pins & wake_en_r;
  // requests already up at entry sit in blocked_r and cannot wake
  assign irq_wake = irq_req & ~blocked_r;
  assign any_wake = (|pin_fall) | (|irq_wake) | ovf;
  assign key_reset = key_pend_r & (key_dly_r == '0);
  // entry only from run; an overflow in the same cycle wins and stays in run
  assign pd_enter = pdown_instr & (mode_r == wdw_pkg::WDW_RUN) & ~ovf;

  // readdata loads while waitrequest is high, so it stands once that drops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h0000_0000;
    end else begin
      waitrequest_r <= waitrequest_nxt;
      if (rd_take) begin
        readdata_r <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_hit(avs_address, wdw_pkg::OFS_WDT_CTRL)) begin
      rd_mux[7:0] = wdt_ctrl_r;
    end else if (sel_hit(avs_address, wdw_pkg::OFS_RST_CAUSE)) begin
      rd_mux[wdw_pkg::RC_WDT_KEY] = wdt_key_flag_r;
    end else if (sel_hit(avs_address, wdw_pkg::OFS_WAKE_EN)) begin
      rd_mux[PINS-1:0] = wake_en_r;
    end else if (sel_hit(avs_address, wdw_pkg::OFS_IRQ_STATUS)) begin
      rd_mux[EV_W_C-1:0] = irq_status_r;
    end else if (sel_hit(avs_address, wdw_pkg::OFS_IRQ_MASK)) begin
      rd_mux[EV_W_C-1:0] = irq_mask_r;
    end else if (sel_hit(avs_address, wdw_pkg::OFS_STATUS)) begin
      rd_mux[wdw_pkg::ST_PDF]  = pdf_r;
      rd_mux[wdw_pkg::ST_TO]   = to_r;
      rd_mux[wdw_pkg::ST_DOWN] = is_down(mode_r);
    end
  end

  // control register; an illegal key restores the power-on value at reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdt_ctrl_r <= wdw_pkg::WDT_CTRL_POR;
    end else if (key_reset) begin
      wdt_ctrl_r <= wdw_pkg::WDT_CTRL_POR;
    end else if (wr_take & avs_byteenable[0] &
                 sel_hit(avs_address, wdw_pkg::OFS_WDT_CTRL)) begin
      wdt_ctrl_r <= avs_writedata[7:0];
    end
  end

  // key check: any value but enable or disable arms a delayed reset
  // the bad key stays in control meanwhile, so the count halts too
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      key_pend_r <= 1'b0;
      key_dly_r  <= '0;
    end else if (wr_take & avs_byteenable[0] & ~key_pend_r &
                 sel_hit(avs_address, wdw_pkg::OFS_WDT_CTRL) &
                 key_wr != wdw_pkg::KEY_ENABLE &
                 key_wr != wdw_pkg::KEY_DISABLE) begin
      key_pend_r <= 1'b1;
      key_dly_r  <= DLY_W'(KEY_DELAY_CYC - 1);
    end else if (key_reset) begin
      key_pend_r <= 1'b0;
    end else if (key_pend_r) begin
      key_dly_r <= key_dly_r - 1'b1;
    end
  end

  // key reset flag: hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdt_key_flag_r <= 1'b0;
    end else if (key_reset) begin
      wdt_key_flag_r <= 1'b1;
    end else if (wr_take & avs_byteenable[0] &
                 sel_hit(avs_address, wdw_pkg::OFS_RST_CAUSE) &
                 ~avs_writedata[wdw_pkg::RC_WDT_KEY]) begin
      wdt_key_flag_r <= 1'b0;
    end
  end

  // wake enable and interrupt mask are plain read-write copies
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_en_r  <= '0;
      irq_mask_r <= '0;
    end else if (wr_take & avs_byteenable[0]) begin
      if (sel_hit(avs_address, wdw_pkg::OFS_WAKE_EN)) begin
        wake_en_r <= avs_writedata[PINS-1:0];
      end
      if (sel_hit(avs_address, wdw_pkg::OFS_IRQ_MASK)) begin
        irq_mask_r <= avs_writedata[EV_W_C-1:0];
      end
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  always_comb begin
    ev_set = '0;
    ev_set[wdw_pkg::EV_OVF]  = ovf;
    ev_set[wdw_pkg::EV_KEY]  = key_reset;
    ev_set[wdw_pkg::EV_WAKE] = is_down(mode_r) & any_wake;
    ev_clr = '0;
    if (wr_take & avs_byteenable[0] &
        sel_hit(avs_address, wdw_pkg::OFS_IRQ_STATUS)) begin
      ev_clr = avs_writedata[EV_W_C-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_r <= '0;
      irq_r        <= 1'b0;
    end else begin
      irq_status_r <= (irq_status_r & ~ev_clr) | ev_set;
      // a cycle behind status so irq leaves a flop
      irq_r        <= |(irq_status_r & irq_mask_r);
    end
  end

  // watchdog count; a disabled watchdog holds its count
  // clears beat the restart, which beats a count step
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r      <= '0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= slow_internal_osc;
      if (key_reset | clrwdt_instr | pdown_instr) begin
        cnt_r <= '0;
      end else if (ovf) begin
        cnt_r <= '0;
      end else if (wdt_en & osc_tick) begin
        cnt_r <= cnt_inc;
      end
    end
  end

  // power mode and wake decisions
  // wake priority: key reset, overflow, interrupt, then pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r         <= wdw_pkg::WDW_RUN;
      pins_prev_r    <= '0;
      blocked_r      <= '0;
      wake_resume_r  <= 1'b0;
      wake_service_r <= 1'b0;
      pc_sp_reset_r  <= 1'b0;
      device_reset_r <= 1'b0;
    end else begin
      pins_prev_r    <= wake_pins;
      wake_resume_r  <= 1'b0;
      wake_service_r <= 1'b0;
      pc_sp_reset_r  <= 1'b0;
      device_reset_r <= key_reset;
      case (mode_r)
        wdw_pkg::WDW_RUN: begin
          if (ovf) begin
            device_reset_r <= 1'b1;
          end else if (pdown_instr) begin
            mode_r    <= wdw_pkg::WDW_DOWN;
            blocked_r <= irq_req;
          end
        end
        wdw_pkg::WDW_DOWN: begin
          if (key_reset) begin
            mode_r <= wdw_pkg::WDW_RUN;
          end else if (ovf) begin
            mode_r        <= wdw_pkg::WDW_RUN;
            pc_sp_reset_r <= 1'b1;
          end else if (|irq_wake) begin
            mode_r <= wdw_pkg::WDW_RUN;
            if ((|(irq_wake & irq_enabled)) & ~stack_full) begin
              wake_service_r <= 1'b1;
            end else begin
              wake_resume_r <= 1'b1;
            end
          end else if (|pin_fall) begin
            mode_r        <= wdw_pkg::WDW_RUN;
            wake_resume_r <= 1'b1;
          end
        end
        default: begin
          mode_r <= wdw_pkg::WDW_RUN;
        end
      endcase
    end
  end

  // status flags survive the device resets this block requests
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      if (pd_enter) begin
        pdf_r <= 1'b1;
      end else if (clrwdt_instr) begin
        pdf_r <= 1'b0;
      end
      if (ovf) begin
        to_r <= 1'b1;
      end else if (pd_enter) begin
        to_r <= 1'b0;
      end
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign low_power       = is_down(mode_r);
  assign wake_resume     = wake_resume_r;
  assign wake_service    = wake_service_r;
  assign pc_sp_reset     = pc_sp_reset_r;
  assign device_reset    = device_reset_r;
  assign power_down_flag = pdf_r;
  assign timeout_flag    = to_r;
  assign irq             = irq_r;
endmodule
`default_nettype wire

// *** bench/wdw_top_assertions.sv ***
// wdw_top_assertions: port-level checks for wdw_top, bound at the foot.
// assumes one clk_sys domain and the async active-low rst_b.
`timescale 1ns/10ps
`default_nettype none
module wdw_top_assertions #(
  parameter int KEY_DELAY_CYC = 20
) (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        pdown_instr,
  input wire logic        clrwdt_instr,
  input wire logic        stack_full,
  input wire logic        low_power,
  input wire logic        wake_resume,
  input wire logic        wake_service,
  input wire logic        pc_sp_reset,
  input wire logic        device_reset,
  input wire logic        power_down_flag,
  input wire logic        timeout_flag
);
  // slack of a few edges: the pulse is registered after the delay count
  localparam int KD_LO = KEY_DELAY_CYC - 1;
  localparam int KD_HI = KEY_DELAY_CYC + 3;
  logic [3:0] pulses;
  assign pulses = {device_reset, pc_sp_reset, wake_service, wake_resume};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_pdown_enter;
    pdown_instr && !low_power |=> low_power && power_down_flag && !timeout_flag;
  endproperty
  a_pdown_enter: assert property (p_pdown_enter)
    else $error("power-down entry wrong");
  property p_clr_pdf;
    clrwdt_instr && !pdown_instr |=> !power_down_flag;
  endproperty
  a_clr_pdf: assert property (p_clr_pdf)
    else $error("clear-watchdog left power-down flag set");
  property p_wake_cause;
    $fell(low_power) |-> pulses != 4'h0;
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("left low power with no wake pulse");
  property p_wake_down;
    pulses[2:0] != 3'h0 |-> $past(low_power);
  endproperty
  a_wake_down: assert property (p_wake_down)
    else $error("wake pulse while running");
  property p_one_pulse;
    $onehot0(pulses);
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("more than one outcome pulse");
  property p_ovf_down;
    pc_sp_reset |-> timeout_flag && power_down_flag && !low_power;
  endproperty
  a_ovf_down: assert property (p_ovf_down)
    else $error("sleep overflow flags wrong");
  property p_rose_to;
    $rose(timeout_flag) |-> pc_sp_reset || device_reset;
  endproperty
  a_rose_to: assert property (p_rose_to)
    else $error("timeout flag rose without a reset");
  property p_service;
    wake_service |-> !$past(stack_full);
  endproperty
  a_service: assert property (p_service)
    else $error("interrupt response with full stack");
  property p_key_delay;
    avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == wdw_pkg::OFS_WDT_CTRL
      && avs_writedata[7:3] != wdw_pkg::KEY_ENABLE
      && avs_writedata[7:3] != wdw_pkg::KEY_DISABLE
      |-> ##[KD_LO:KD_HI] device_reset;
  endproperty
  a_key_delay: assert property (p_key_delay)
    else $error("illegal key gave no timed reset");
  property p_bus_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1
      avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans)
    else $error("bus answer not one wait cycle");
endmodule
bind wdw_top wdw_top_assertions #(.KEY_DELAY_CYC(KEY_DELAY_CYC))
  wdw_top_assertions_inst (.clk_sys, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .pdown_instr,
  .clrwdt_instr, .stack_full, .low_power, .wake_resume, .wake_service,
  .pc_sp_reset, .device_reset, .power_down_flag, .timeout_flag);
`default_nettype wire

// *** bench/wdw_cpu_model.sv ***
// wdw_cpu_model: far side of wdw_top, slow oscillator and cpu outcome log.
// assumes the bench issues the cpu instructions; this model counts results.
`timescale 1ns/10ps
`default_nettype none
module wdw_cpu_model (
  input  wire logic   clk_sys,
  input  wire logic   rst_b,
  input  wire logic   device_reset,
  input  wire logic   wake_resume,
  input  wire logic   wake_service,
  input  wire logic   pc_sp_reset,
  output logic        slow_internal_osc,
  output logic [15:0] n_rst,
  output logic [15:0] n_wake
);
  // free running; one slow edge per two system clocks keeps runs short
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slow_internal_osc <= 1'b0;
    end else begin
      slow_internal_osc <= ~slow_internal_osc;
    end
  end
  // a full reset restarts the core; a wake resumes, vectors or rewinds it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      n_rst <= 16'h0;
      n_wake <= 16'h0;
    end else begin
      n_rst <= n_rst + 16'(device_reset);
      n_wake <= n_wake + 16'(wake_resume | wake_service | pc_sp_reset);
    end
  end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// tb: self-checking bench for wdw_top over avalon-mm and cpu strobes.
// assumes wdw_pkg is compiled first and wdw_cpu_model is the far side.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [7:0] A_CTL = wdw_pkg::OFS_WDT_CTRL;
  localparam logic [7:0] A_RC = wdw_pkg::OFS_RST_CAUSE;
  localparam logic [7:0] A_ST = wdw_pkg::OFS_STATUS;
  localparam logic [7:0] A_IS = wdw_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] A_IM = wdw_pkg::OFS_IRQ_MASK;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        pdown_instr = 1'b0;
  logic        clrwdt_instr = 1'b0;
  logic [7:0]  wake_pins = 8'hff;
  logic [7:0]  irq_req = 8'h00;
  logic [7:0]  irq_enabled = 8'h00;
  logic        stack_full = 1'b0;
  logic [31:0] avs_readdata, d;
  logic        avs_waitrequest, slow_internal_osc, low_power, wake_resume;
  logic        wake_service, pc_sp_reset, device_reset, irq;
  logic        power_down_flag, timeout_flag;
  logic [15:0] n_rst, n_wake;
  logic [3:0]  ev;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc;
  always #25 clk_sys = ~clk_sys;
  // short key delay keeps the run brief; expectations use the same figure
  wdw_top #(.KEY_DELAY_CYC(4)) wdw_top_inst (.clk_sys, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .pdown_instr, .clrwdt_instr, .slow_internal_osc,
    .wake_pins, .irq_req, .irq_enabled, .stack_full, .low_power, .wake_resume,
    .wake_service, .pc_sp_reset, .device_reset, .power_down_flag,
    .timeout_flag, .irq);
  wdw_cpu_model wdw_cpu_model_inst (.clk_sys, .rst_b, .device_reset,
    .wake_resume, .wake_service, .pc_sp_reset, .slow_internal_osc, .n_rst,
    .n_wake);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= v;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask
  task automatic strobe(input logic pd);
    @(posedge clk_sys);
    pdown_instr <= pd;
    clrwdt_instr <= !pd;
    @(posedge clk_sys);
    pdown_instr <= 1'b0;
    clrwdt_instr <= 1'b0;
  endtask
  // ev bits: device reset, pc/sp reset, interrupt response, resume
  task automatic wait_ev(input logic [3:0] m, input int lim);
    cyc = 0;
    ev = 4'h0;
    while (cyc < lim && (ev & m) == 4'h0) begin
      @(posedge clk_sys);
      cyc++;
      ev = {device_reset, pc_sp_reset, wake_service, wake_resume};
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(A_CTL, 32'h53);
    rd_chk(A_ST, 32'h0);
    rd_chk(A_RC, 32'h0);
    bus(1'b1, 8'h3c, 32'hff);
    rd_chk(8'h3c, 32'h0);
    $display("reset test done");
    for (int s = 0; s < 3; s++) begin
      strobe(1'b0);
      bus(1'b1, A_CTL, {24'h0, wdw_pkg::KEY_ENABLE, 3'(s)});
      wait_ev(4'h8, 3000);
      d = cyc + 3 - (512 << s);
      chk(d + 8 <= 16, 1);
      chk(timeout_flag, 1);
    end
    $display("period test done");
    bus(1'b0, A_IS, 32'h0);
    chk(d[0], 1);
    bus(1'b1, A_IM, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    bus(1'b1, A_IM, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1);
    bus(1'b1, A_IS, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    $display("interrupt test done");
    strobe(1'b0);
    bus(1'b1, A_CTL, {24'h0, wdw_pkg::KEY_ENABLE, 3'h0});
    strobe(1'b1);
    @(posedge clk_sys);
    chk({low_power, power_down_flag, timeout_flag}, 3'b110);
    wait_ev(4'hf, 700);
    chk({ev, low_power, power_down_flag, timeout_flag}, 7'h23);
    strobe(1'b0);
    chk(irq, 1);
    rd_chk(A_ST, 32'h2);
    $display("sleep overflow test done");
    bus(1'b1, A_CTL, {24'h0, wdw_pkg::KEY_DISABLE, 3'h0});
    strobe(1'b0);
    wait_ev(4'hf, 1200);
    chk(ev, 4'h0);
    bus(1'b1, wdw_pkg::OFS_WAKE_EN, 32'h1);
    strobe(1'b1);
    wake_pins <= 8'hfd;
    wait_ev(4'hf, 10);
    chk({ev, low_power}, 5'h01);
    wake_pins <= 8'hfc;
    wait_ev(4'hf, 10);
    chk(ev, 4'h1);
    wake_pins <= 8'hff;
    irq_req <= 8'h04;
    strobe(1'b1);
    wait_ev(4'hf, 10);
    chk({ev, low_power}, 5'h01);
    irq_req <= 8'h00;
    rd_chk(A_ST, 32'h5);
    rd_chk(wdw_pkg::OFS_WAKE_EN, 32'h1);
    for (int k = 0; k < 3; k++) begin
      stack_full <= (k == 2);
      irq_enabled <= (k == 1) ? 8'h00 : 8'h08;
      if (low_power !== 1'b1) strobe(1'b1);
      @(posedge clk_sys);
      irq_req <= 8'h08;
      wait_ev(4'hf, 10);
      chk(ev, (k == 0) ? 4'h2 : 4'h1);
      irq_req <= 8'h00;
    end
    $display("wake test done");
    bus(1'b1, A_CTL, 32'h3);
    wait_ev(4'h8, 40);
    chk(ev, 4'h8);
    rd_chk(A_RC, 32'h1);
    rd_chk(A_CTL, 32'h53);
    bus(1'b1, A_RC, 32'h0);
    rd_chk(A_RC, 32'h0);
    rd_chk(A_IS, 32'h7);
    rd_chk(A_IM, 32'h1);
    chk({n_rst, n_wake}, {16'd4, 16'd5});
    $display("key test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
